// ---- common/ldc_pkg.sv ----
// Package for the four-channel linear regulator control block.
// Assumes one synchronous clock domain; no register bus, all fields are plain ports.
package ldc_pkg;
    localparam int          LDC_CHANNELS    = 4;
    localparam int          LDC_CODE_W      = 4;
    localparam logic [3:0]  LDC_CODE_MIN    = 4'h0;    // Lowest set point, 1.5 V.
    localparam logic        LDC_ENABLE_RST  = 1'b0;
    // Soft-start ramp length in microseconds, and in cycles at 125 MHz.
    localparam int          LDC_CLK_MHZ     = 125;
    localparam int          LDC_RAMP_US     = 100;
    localparam int          LDC_RAMP_CYC    = LDC_RAMP_US * LDC_CLK_MHZ;
    // Discharge hold after disable, in microseconds and cycles.
    localparam int          LDC_DIS_US      = 100;
    localparam int          LDC_DIS_CYC     = LDC_DIS_US * LDC_CLK_MHZ;
    localparam int          LDC_CNT_W       = 16;

    // Operating mode of one regulator.
    typedef enum logic [2:0] {
        LDC_OFF    = 3'h1,
        LDC_NORMAL = 3'h2,
        LDC_SWITCH = 3'h4
    } ldc_mode_t;

    // Phase of a regulator's output sequencing.
    typedef enum logic [2:0] {
        LDC_IDLE   = 3'h1,
        LDC_RAMP   = 3'h2,
        LDC_ON     = 3'h4
    } ldc_phase_t;
endpackage : ldc_pkg

// ---- common/ldc_chan_if.sv ----
// Interface carrying one channel's settings into its sequencer and its state back.
// Assumes both ends share clk_in.
`timescale 1ns/1ns
`default_nettype none
interface ldc_chan_if;
    import ldc_pkg::*;
    logic                  active;      // Enable bit for the current state.
    logic                  switch_fuse; // Load-switch selector.
    logic                  enabled;     // Registered: regulating or switching.
    logic                  load_switch; // Registered: on as a load switch.
    logic                  ramping;
    logic                  discharging;
    logic                  pull_down;
    modport ctrl (output active, output switch_fuse, input enabled, input load_switch,
                  input ramping, input discharging, input pull_down);
    modport seq  (input active, input switch_fuse, output enabled, output load_switch,
                  output ramping, output discharging, output pull_down);
endinterface : ldc_chan_if
`default_nettype wire

// ---- design/ldc_channel_seq.sv ----
// One regulator's mode decoder, soft-start ramp and discharge timer.
// Assumes settings arrive synchronous to clk_in through ldc_chan_if.
`timescale 1ns/1ns
`default_nettype none
module ldc_channel_seq
    import ldc_pkg::*;
#(
    parameter int RAMP_CYC = LDC_RAMP_CYC,
    parameter int DIS_CYC  = LDC_DIS_CYC
) (
    // Clock and reset.
    input  wire logic      clk_in,
    input  wire logic      resetn_in,
    // Channel link.
    ldc_chan_if.seq        ch
);
    ldc_phase_t            phase, next_phase;
    logic [LDC_CNT_W-1:0]  ramp_cnt, next_ramp_cnt;
    logic [LDC_CNT_W-1:0]  dis_cnt, next_dis_cnt;
    ldc_mode_t             next_mode;
    logic                  pd, next_pd;
    // Output flags, decoded from the next values so that each leaves on a flop.
    logic                  en, next_en;
    logic                  ls, next_ls;
    logic                  ss, next_ss;
    logic                  dis, next_dis;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: disabled wins over the selector, so the fuse cannot hold an output on.
    always_comb begin
        next_phase    = phase;
        next_ramp_cnt = ramp_cnt;
        next_dis_cnt  = (dis_cnt != '0) ? dis_cnt - 1'b1 : dis_cnt;
        next_mode     = LDC_OFF;
        next_pd       = 1'b1;
        if (!ch.active) begin
            next_mode = LDC_OFF;
            next_pd   = 1'b1;
            if (phase != LDC_IDLE) begin
                next_dis_cnt = LDC_CNT_W'(DIS_CYC);
            end
            next_phase    = LDC_IDLE;
            next_ramp_cnt = '0;
        end else begin
            next_mode = ch.switch_fuse ? LDC_SWITCH : LDC_NORMAL;
            next_pd   = 1'b0;
            next_dis_cnt = '0;
            unique case (phase)
                LDC_IDLE: begin
                    next_phase    = LDC_RAMP;
                    next_ramp_cnt = LDC_CNT_W'(RAMP_CYC);
                end
                LDC_RAMP: begin
                    next_ramp_cnt = ramp_cnt - 1'b1;
                    if (ramp_cnt == LDC_CNT_W'(1)) begin
                        next_phase = LDC_ON;
                    end
                end
                LDC_ON: begin
                    next_phase = LDC_ON;
                end
                default: begin
                    next_phase = LDC_IDLE;
                end
            endcase
        end
        // Flags for the ports follow the next values, one cycle ahead of their flops.
        next_en  = (next_mode != LDC_OFF);
        next_ls  = (next_mode == LDC_SWITCH);
        next_ss  = (next_phase == LDC_RAMP);
        next_dis = (next_dis_cnt != '0);
    end

    // Register stage.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            phase    <= LDC_IDLE;
            ramp_cnt <= '0;
            dis_cnt  <= '0;
            en       <= 1'b0;
            ls       <= 1'b0;
            ss       <= 1'b0;
            dis      <= 1'b0;
            pd       <= 1'b1;
        end else begin
            phase    <= next_phase;
            ramp_cnt <= next_ramp_cnt;
            dis_cnt  <= next_dis_cnt;
            en       <= next_en;
            ls       <= next_ls;
            ss       <= next_ss;
            dis      <= next_dis;
            pd       <= next_pd;
        end
    end

    assign ch.enabled     = en;
    assign ch.load_switch = ls;
    assign ch.ramping     = ss;
    assign ch.discharging = dis;
    assign ch.pull_down   = pd;
endmodule : ldc_channel_seq
`default_nettype wire

// ---- design/ldc_enable_voltage_ctrl.sv ----
// Enable and voltage control for four linear regulators.
// Assumes fuse inputs are stable from reset and the sequencer strobes are synchronous.
// Assumes software holds off code writes for the one cycle after reset release.
// Analog parts take the flag outputs as levels; ramp and discharge lengths are counts here.
// Behaviour
// - Four independent channels, each with enables, selector and two voltage codes.
// - In run mode a clear run enable turns the output off.
// - In standby a clear standby enable turns the output off.
// - Power-up sequence sets enables of sequenced channels; others reset to zero.
// - Normal or load-switch choice comes only from the fuse selector bit.
// - Enable clear means disabled with pull-down, selector ignored.
// - Enable set and selector clear means normal regulation.
// - Enable set and selector set means load-switch operation.
// - Four-bit run code drives the output setting in run mode.
// - Four-bit standby code drives the output setting in standby.
// - Both codes load from the fuse default at power-up.
// - Codes span 1.5 V to 5.0 V; code zero is 1.5 V.
// - Disabled to enabled starts a soft-start ramp.
// - Enabled to disabled activates the discharge path.
`timescale 1ns/1ns
`default_nettype none
module ldc_enable_voltage_ctrl
    import ldc_pkg::*;
#(
    parameter int N        = LDC_CHANNELS,
    parameter int RAMP_CYC = LDC_RAMP_CYC,
    parameter int DIS_CYC  = LDC_DIS_CYC
) (
    // Clock and reset.
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    // System state: high for standby, low for run.
    input  wire logic                  standby_in,
    // Fuse configuration.
    input  wire logic [N-1:0]          reg_switch_mode_fuse_in,
    input  wire logic [N*4-1:0]        reg_voltage_fuse_default_in,
    input  wire logic [N-1:0]          seq_member_fuse_in,
    // Power-up sequencer: set enables of sequenced members.
    input  wire logic                  seq_power_up_in,
    // Software writes.
    input  wire logic [N-1:0]          run_enable_wr_in,
    input  wire logic [N-1:0]          standby_enable_wr_in,
    input  wire logic [N-1:0]          run_code_wr_in,
    input  wire logic [N-1:0]          standby_code_wr_in,
    input  wire logic [N-1:0]          enable_wdata_in,
    input  wire logic [N*4-1:0]        code_wdata_in,
    // Field read-back.
    output logic [N-1:0]               reg_run_enable_out,
    output logic [N-1:0]               reg_standby_enable_out,
    output logic [N*4-1:0]             reg_run_voltage_code_out,
    output logic [N*4-1:0]             reg_standby_voltage_code_out,
    // Analog controls per channel.
    output logic [N-1:0]               enabled_out,
    output logic [N-1:0]               load_switch_out,
    output logic [N-1:0]               pull_down_out,
    output logic [N-1:0]               soft_start_out,
    output logic [N-1:0]               discharge_out,
    output logic [N*4-1:0]             voltage_set_out
);
    // Width of one channel's code nibble inside the packed buses.
    localparam int CW = LDC_CODE_W;

    // Field state.
    logic [N-1:0]    run_en, next_run_en;
    logic [N-1:0]    stby_en, next_stby_en;
    logic [N*CW-1:0] run_code, next_run_code;
    logic [N*CW-1:0] stby_code, next_stby_code;
    logic            loaded, next_loaded;
    // Enable and code of the current system state.
    logic [N-1:0]    cur_en;
    logic [N*CW-1:0] cur_code;
    // Per-channel flags, each straight from a flop in its sequencer.
    logic [N-1:0]    ch_en, ch_ls, ch_ss, ch_dis, ch_pd;
    // Output staging.
    logic [N-1:0]    o_en, o_ls, o_pd, o_ss, o_dis;
    logic [N*CW-1:0] o_v, next_o_v;

    ////////////////////////////////////////////////////////////////////////////
    // Enable fields. Reset clears them all; a channel in the power-up sequence has both
    // bits set by the sequencer strobe, which beats a software write of zero in the same
    // cycle so that a stray write cannot keep a sequenced rail down.
    always_comb begin
        next_run_en  = run_en;
        next_stby_en = stby_en;
        for (int i = 0; i < N; i++) begin
            if (run_enable_wr_in[i]) begin
                next_run_en[i] = enable_wdata_in[i];
            end
            if (standby_enable_wr_in[i]) begin
                next_stby_en[i] = enable_wdata_in[i];
            end
            if (seq_power_up_in && seq_member_fuse_in[i]) begin
                next_run_en[i]  = 1'b1;
                next_stby_en[i] = 1'b1;
            end
        end
    end

    // Enable registers. Every channel starts off, whatever its fuses say, until the
    // sequencer strobe or software turns it on.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            run_en  <= {N{LDC_ENABLE_RST}};
            stby_en <= {N{LDC_ENABLE_RST}};
        end else begin
            run_en  <= next_run_en;
            stby_en <= next_stby_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Voltage code fields. The first cycle after reset loads both codes from the fuse
    // default, so a code write in that cycle is lost; software must wait one cycle.
    // The trade keeps the fuse load to a single cycle with no extra handshake.
    always_comb begin
        next_run_code  = run_code;
        next_stby_code = stby_code;
        next_loaded    = 1'b1;
        for (int i = 0; i < N; i++) begin
            if (run_code_wr_in[i]) begin
                next_run_code[i*CW +: CW] = code_wdata_in[i*CW +: CW];
            end
            if (standby_code_wr_in[i]) begin
                next_stby_code[i*CW +: CW] = code_wdata_in[i*CW +: CW];
            end
            if (!loaded) begin
                next_run_code[i*CW +: CW]  = reg_voltage_fuse_default_in[i*CW +: CW];
                next_stby_code[i*CW +: CW] = reg_voltage_fuse_default_in[i*CW +: CW];
            end
        end
    end

    // Code registers; codes sit at the lowest set point until the fuse load, so a
    // rail that is somehow on during that cycle never sees a high target.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            run_code  <= {N{LDC_CODE_MIN}};
            stby_code <= {N{LDC_CODE_MIN}};
            loaded    <= 1'b0;
        end else begin
            run_code  <= next_run_code;
            stby_code <= next_stby_code;
            loaded    <= next_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current-state selection. One mux feeds both the channel enables and the applied
    // code, so a change of system state moves enable and voltage in the same cycle and
    // the two can never disagree about which state is current.
    always_comb begin
        cur_en   = standby_in ? stby_en : run_en;
        cur_code = standby_in ? stby_code : run_code;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel sequencers, one instance each so channels stay independent.
    // The load-switch choice is wired from the fuse only; no software field can
    // reach it, so a bad write cannot turn a regulator into a bare switch.
    for (genvar g = 0; g < N; g++) begin : g_ch
        ldc_chan_if chif ();
        assign chif.active      = cur_en[g];
        assign chif.switch_fuse = reg_switch_mode_fuse_in[g];
        assign ch_en[g]         = chif.enabled;
        assign ch_ls[g]         = chif.load_switch;
        assign ch_ss[g]         = chif.ramping;
        assign ch_dis[g]        = chif.discharging;
        assign ch_pd[g]         = chif.pull_down;
        ldc_channel_seq #(
            .RAMP_CYC (RAMP_CYC),
            .DIS_CYC  (DIS_CYC)
        ) u_seq (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .ch        (chif)
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Applied set point. It follows the current state whether or not the channel is on,
    // so a regulator that is later enabled ramps straight towards the right level.
    // A code written while a channel runs moves the set point without a new ramp.
    always_comb begin
        next_o_v = cur_code;
    end

    // Set point register. The code lands one cycle after the field or the state changes;
    // the field itself needs a cycle more after its write strobe.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            o_v <= {N{LDC_CODE_MIN}};
        end else begin
            o_v <= next_o_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog controls. Each flag is decoded one step early inside its sequencer and
    // registered there, so the ports leave straight from flops with no glue between.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            o_en[i]  = ch_en[i];
            o_ls[i]  = ch_ls[i];
            o_pd[i]  = ch_pd[i];
            o_ss[i]  = ch_ss[i];
            o_dis[i] = ch_dis[i];
        end
    end

    // Field read-back straight from the field registers.
    assign reg_run_enable_out           = run_en;
    assign reg_standby_enable_out       = stby_en;
    assign reg_run_voltage_code_out     = run_code;
    assign reg_standby_voltage_code_out = stby_code;

    // Analog controls and the applied set point.
    assign enabled_out                  = o_en;
    assign load_switch_out              = o_ls;
    assign pull_down_out                = o_pd;
    assign soft_start_out               = o_ss;
    assign discharge_out                = o_dis;
    assign voltage_set_out              = o_v;
endmodule : ldc_enable_voltage_ctrl
`default_nettype wire

// ---- tb/ldc_ctrl_asserts.sv ----
// Checker for the four-channel regulator control block, bound to its top module.
// Assumes one clock domain and counts shortened for simulation; plain delays stay small.
`timescale 1ns/1ns
`default_nettype none
module ldc_ctrl_asserts
    import ldc_pkg::*;
#(
    parameter int N        = LDC_CHANNELS,
    parameter int RAMP_CYC = 5,
    parameter int DIS_CYC  = 5
) (
    // Clock, reset and state.
    input wire logic           clk_in,
    input wire logic           resetn_in,
    input wire logic           standby_in,
    // Fuses and sequencer.
    input wire logic [N-1:0]   reg_switch_mode_fuse_in,
    input wire logic [N*4-1:0] reg_voltage_fuse_default_in,
    input wire logic [N-1:0]   seq_member_fuse_in,
    input wire logic           seq_power_up_in,
    // Observed outputs.
    input wire logic [N-1:0]   reg_run_enable_out,
    input wire logic [N-1:0]   reg_standby_enable_out,
    input wire logic [N*4-1:0] reg_run_voltage_code_out,
    input wire logic [N*4-1:0] reg_standby_voltage_code_out,
    input wire logic [N-1:0]   enabled_out,
    input wire logic [N-1:0]   load_switch_out,
    input wire logic [N-1:0]   pull_down_out,
    input wire logic [N-1:0]   soft_start_out,
    input wire logic [N-1:0]   discharge_out,
    input wire logic [N*4-1:0] voltage_set_out
);
    logic [N-1:0]   act;
    logic [N*4-1:0] sel;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Enable and code of the current state, as the outputs should follow them.
    always_comb begin
        act = standby_in ? reg_standby_enable_out : reg_run_enable_out;
        sel = standby_in ? reg_standby_voltage_code_out : reg_run_voltage_code_out;
    end
    // Fields straight after a reset release or a power-up sequencer strobe.
    AST_FUSE_LOAD: assert property (
        $rose(resetn_in) |=> reg_run_voltage_code_out == reg_voltage_fuse_default_in
        && reg_standby_voltage_code_out == reg_voltage_fuse_default_in)
        else $error("codes not loaded from fuse default");
    AST_EN_RESET: assert property (
        $rose(resetn_in) |-> reg_run_enable_out == '0 && reg_standby_enable_out == '0)
        else $error("enables not clear after reset");
    AST_SEQ_SET: assert property (
        seq_power_up_in |=> (reg_run_enable_out & reg_standby_enable_out
        & seq_member_fuse_in) == seq_member_fuse_in)
        else $error("sequencer did not set member enables");
    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel mode, ramp, discharge and set point.
    for (genvar i = 0; i < N; i++) begin : g_ch
        AST_ON_MODE: assert property (
            act[i] |=> enabled_out[i] && !pull_down_out[i]
            && load_switch_out[i] == reg_switch_mode_fuse_in[i])
            else $error("enabled channel in wrong mode");
        AST_OFF_MODE: assert property (
            !act[i] |=> !enabled_out[i] && pull_down_out[i] && !load_switch_out[i])
            else $error("disabled channel not pulled down");
        AST_RAMP: assert property (
            $rose(enabled_out[i]) |-> soft_start_out[i] ##RAMP_CYC !soft_start_out[i])
            else $error("soft-start ramp wrong");
        AST_DISCHARGE: assert property (
            $fell(enabled_out[i]) |-> discharge_out[i] ##DIS_CYC !discharge_out[i])
            else $error("discharge window wrong");
        AST_SET_POINT: assert property (
            voltage_set_out[4*i+:4] == $past(sel[4*i+:4]))
            else $error("applied code does not follow state");
    end
    // Main scenarios reached.
    C_RISE: cover property ($rose(enabled_out[0]));
    C_FALL: cover property ($fell(enabled_out[0]));
    C_STATE: cover property ($rose(standby_in) ##1 enabled_out[0]);
endmodule : ldc_ctrl_asserts
`default_nettype wire

// ---- tb/tb_ldc_enable_voltage_ctrl.sv ----
// Self-checking bench for the regulator control block: random writes plus corner cases.
// Assumes ramp and discharge counts shortened to five cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_ldc_enable_voltage_ctrl;
    import ldc_pkg::*;
    localparam int N = LDC_CHANNELS;
    // Inputs, all given a value at time zero.
    logic clk_in = 1'b0, resetn_in = 1'b0, standby_in = 1'b0, seq_power_up_in = 1'b0;
    logic [N-1:0] reg_switch_mode_fuse_in = '0, seq_member_fuse_in = '0, enable_wdata_in = '0;
    logic [N-1:0] run_enable_wr_in = '0, standby_enable_wr_in = '0;
    logic [N-1:0] run_code_wr_in = '0, standby_code_wr_in = '0;
    logic [N*4-1:0] reg_voltage_fuse_default_in = '0, code_wdata_in = '0;
    // Outputs.
    logic [N-1:0] reg_run_enable_out, reg_standby_enable_out, enabled_out, load_switch_out;
    logic [N-1:0] pull_down_out, soft_start_out, discharge_out;
    logic [N*4-1:0] reg_run_voltage_code_out, reg_standby_voltage_code_out, voltage_set_out;
    // Bench copy of the fields.
    logic [N-1:0] m_ren, m_sen;
    logic [N*4-1:0] m_rc, m_sc;
    logic [31:0] r, q;
    int seed = 95, n_fail = 0, tests_run = 0, cycles = 0;
    ldc_enable_voltage_ctrl #(.N(N), .RAMP_CYC(5), .DIS_CYC(5)) i_dut (
        .clk_in, .resetn_in, .standby_in, .reg_switch_mode_fuse_in,
        .reg_voltage_fuse_default_in, .seq_member_fuse_in, .seq_power_up_in,
        .run_enable_wr_in, .standby_enable_wr_in, .run_code_wr_in, .standby_code_wr_in,
        .enable_wdata_in, .code_wdata_in, .reg_run_enable_out, .reg_standby_enable_out,
        .reg_run_voltage_code_out, .reg_standby_voltage_code_out, .enabled_out,
        .load_switch_out, .pull_down_out, .soft_start_out, .discharge_out, .voltage_set_out);
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above the planned run of some 1230 cycles.
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected value of whatever follows the current system state.
    function automatic logic [15:0] pick(input logic sb, input logic [15:0] run_v, stby_v);
        return sb ? stby_v : run_v;
    endfunction
    // Fields one cycle after a write, then outputs once ramps and discharges are over.
    task automatic settle();
        logic [N-1:0] a;
        check(reg_run_enable_out, m_ren);
        check(reg_standby_enable_out, m_sen);
        check(reg_run_voltage_code_out, m_rc);
        check(reg_standby_voltage_code_out, m_sc);
        repeat (12) @(negedge clk_in);
        a = N'(pick(standby_in, 16'(m_ren), 16'(m_sen)));
        check(enabled_out, a);
        check(load_switch_out, a & reg_switch_mode_fuse_in);
        check(pull_down_out, N'(~a));
        check(soft_start_out | discharge_out, '0);
        check(voltage_set_out, pick(standby_in, m_rc, m_sc));
    endtask
    // A code write in the release cycle must lose to the fuse load.
    task automatic do_reset();
        resetn_in = 1'b0;
        repeat (20) @(negedge clk_in);
        resetn_in = 1'b1;
        run_code_wr_in = '1;
        code_wdata_in = ~reg_voltage_fuse_default_in;
        {m_ren, m_sen} = '0;
        m_rc = reg_voltage_fuse_default_in;
        m_sc = reg_voltage_fuse_default_in;
        @(negedge clk_in);
        run_code_wr_in = '0;
        settle();
    endtask
    task automatic step(input logic [N-1:0] rw, sw, rcw, scw, ed, input logic [15:0] cd,
                        input logic sb, sq);
        @(negedge clk_in);
        {run_enable_wr_in, standby_enable_wr_in, run_code_wr_in, standby_code_wr_in} =
            {rw, sw, rcw, scw};
        {enable_wdata_in, code_wdata_in, standby_in, seq_power_up_in} = {ed, cd, sb, sq};
        for (int i = 0; i < N; i++) begin
            if (rw[i]) m_ren[i] = ed[i];
            if (sw[i]) m_sen[i] = ed[i];
            if (sq && seq_member_fuse_in[i]) {m_ren[i], m_sen[i]} = 2'h3;
            if (rcw[i]) m_rc[4*i+:4] = cd[4*i+:4];
            if (scw[i]) m_sc[4*i+:4] = cd[4*i+:4];
        end
        @(negedge clk_in);
        {run_enable_wr_in, standby_enable_wr_in, run_code_wr_in, standby_code_wr_in} = '0;
        seq_power_up_in = 1'b0;
        settle();
    endtask
    task automatic rand_steps();
        repeat (40) begin
            r = $random(seed);
            q = $random(seed);
            step(r[3:0], r[7:4], r[11:8], r[15:12], r[19:16], q[15:0], r[20], &r[23:21]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the second pass inverts every fuse so each selector value is seen.
    initial begin
        r = $random(seed);
        {reg_switch_mode_fuse_in, seq_member_fuse_in, reg_voltage_fuse_default_in} = r[23:0];
        do_reset();
        step('1, '1, '0, '0, '0, 16'h0000, 1'b0, 1'b1);
        step('0, '0, '1, '1, '0, 16'h0000, 1'b0, 1'b0);
        step('1, '1, '1, '1, '1, 16'hFFFF, 1'b1, 1'b0);
        rand_steps();
        reg_switch_mode_fuse_in = ~reg_switch_mode_fuse_in;
        seq_member_fuse_in = ~seq_member_fuse_in;
        reg_voltage_fuse_default_in = ~reg_voltage_fuse_default_in;
        do_reset();
        rand_steps();
        tally_and_finish();
    end
endmodule : tb_ldc_enable_voltage_ctrl
bind ldc_enable_voltage_ctrl ldc_ctrl_asserts #(.N(N), .RAMP_CYC(RAMP_CYC), .DIS_CYC(DIS_CYC))
    i_chk (.clk_in, .resetn_in, .standby_in, .reg_switch_mode_fuse_in,
    .reg_voltage_fuse_default_in, .seq_member_fuse_in, .seq_power_up_in,
    .reg_run_enable_out, .reg_standby_enable_out, .reg_run_voltage_code_out,
    .reg_standby_voltage_code_out, .enabled_out, .load_switch_out, .pull_down_out,
    .soft_start_out, .discharge_out, .voltage_set_out);
`default_nettype wire
